// *** rtl/uocis_pkg.sv ***
package uocis_pkg;
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          IDLE_US         = 3000;
   localparam int          IDLE_CYC        = (IDLE_US * (CLK_HZ / 1_000_000));
   localparam int          B_PORT          = 24;
   localparam int          B_RSTDET        = 23;
   localparam int          B_FETCH         = 22;
   localparam int          B_INCOUT        = 21;
   localparam int          B_INCIN         = 20;
   localparam int          B_OEP           = 19;
   localparam int          B_IEP           = 18;
   localparam int          B_MIS           = 17;
   localparam int          B_RSTR          = 16;
   localparam int          B_PERIODIC_FRAME_END_FLAG          = 15;
   localparam int          B_DROP          = 14;
   localparam int          B_ENUM          = 13;
   localparam int          B_BRST          = 12;
   localparam int          B_SUSP          = 11;
   localparam int          B_EARLY         = 10;
   localparam int          B_TWI           = 9;
   localparam int          B_CAR           = 8;
   localparam int          B_ONAK          = 7;
   localparam int          B_INAK          = 6;
   localparam int          B_NPTX          = 5;
   localparam int          B_RXF           = 4;
   localparam logic [31:0] W1C_MASK        = 32'h00f3_ff00;
   localparam logic [31:0] STATUS_RESET    = 32'h0000_0020;
   localparam logic [1:0]  HIBERNATE_OPT   = 2'h2;
   typedef struct packed {
      logic port_change;
      logic reset_in_suspend;
      logic fetch_stalled;
      logic periodic_incomplete;
      logic iso_out_incomplete;
      logic iso_in_incomplete;
      logic mismatch_expired;
      logic restore_done;
      logic frame_interval;
      logic iso_out_drop;
      logic enum_done;
      logic bus_reset;
      logic bus_suspend;
      logic bus_idle;
      logic two_wire_done;
      logic carkit_event;
      logic out_nak_applied;
      logic in_nak_sampled;
   } uocis_evt_s;
   typedef struct packed {
      logic host_mode;
      logic dma_mode;
      logic sg_dma_mode;
      logic dedicated_tx_fifos_option;
      logic [1:0] power_saving_option;
      logic hibernating;
      logic partial_or_gated;
      logic in_l2_suspend;
      logic two_wire_enabled;
      logic carkit_enabled;
      logic nonperiodic_empty_level;
   } uocis_cfg_s;
   typedef struct packed {
      logic oep_pending;
      logic iep_pending;
      logic port_pending;
      logic np_half_empty;
      logic np_full_empty;
      logic np_queue_room;
      logic rx_packets;
      logic stall_active;
      logic clear_out_nak_ctrl;
      logic clear_in_nak_ctrl;
   } uocis_lvl_s;
endpackage

// *** rtl/uocis_core.sv ***
`timescale 1ns/10ps
module uocis_core
   import uocis_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // register access
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic [31:0] irq_mask,
   // sources
   input  wire uocis_evt_s  evt,
   input  wire uocis_cfg_s  cfg,
   input  wire uocis_lvl_s  lvl,
   // results
   output logic [31:0]      core_interrupt_status,
   output logic             restore_resume,
   output logic             in_nak_reply,
   output logic             irq
);
   logic        rs1_reg;
   logic        rst_sync_b;
   logic [31:0] sts_reg;
   logic [31:0] sts_next;
   logic [31:0] set_vec;
   logic [31:0] w1c_vec;
   logic        onak_reg;
   logic        onak_next;
   logic        inak_reg;
   logic        inak_next;
   logic [16:0] idle_cnt_reg;
   logic [16:0] idle_cnt_next;
   logic        idle_hit;
   logic        irq_reg;
   logic        resume_reg;
   logic        nakr_reg;

   // reset release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rs1_reg    <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rs1_reg    <= 1'b1;
         rst_sync_b <= rs1_reg;
      end
   end

   // idle timer
   always_comb begin
      idle_cnt_next = idle_cnt_reg;
      idle_hit      = 1'b0;
      if (!evt.bus_idle) begin
         idle_cnt_next = 17'h0_0000;
      end else if (idle_cnt_reg != 17'(IDLE_CYC)) begin
         idle_cnt_next = idle_cnt_reg + 17'h0_0001;
         idle_hit      = (idle_cnt_reg == 17'(IDLE_CYC - 1));
      end
   end

   // event set vector
   always_comb begin
      set_vec           = 32'h0000_0000;
      set_vec[B_RSTDET] = !cfg.host_mode && evt.reset_in_suspend && cfg.in_l2_suspend
                          && cfg.partial_or_gated && !cfg.hibernating;
      set_vec[B_FETCH]  = cfg.dma_mode && evt.fetch_stalled;
      set_vec[B_INCOUT] = cfg.host_mode ? evt.periodic_incomplete
                          : (evt.iso_out_incomplete && evt.frame_interval);
      set_vec[B_INCIN]  = !cfg.sg_dma_mode && evt.iso_in_incomplete && evt.frame_interval;
      set_vec[B_MIS]    = !cfg.dedicated_tx_fifos_option && evt.mismatch_expired;
      set_vec[B_RSTR]   = (cfg.power_saving_option == HIBERNATE_OPT) && evt.restore_done;
      set_vec[B_PERIODIC_FRAME_END_FLAG]   = !cfg.host_mode && evt.frame_interval;
      set_vec[B_DROP]   = evt.iso_out_drop;
      set_vec[B_ENUM]   = evt.enum_done;
      set_vec[B_BRST]   = evt.bus_reset;
      set_vec[B_SUSP]   = evt.bus_suspend;
      set_vec[B_EARLY]  = idle_hit;
      set_vec[B_TWI]    = cfg.two_wire_enabled && evt.two_wire_done;
      set_vec[B_CAR]    = cfg.carkit_enabled && evt.carkit_event;
   end

   // sticky and level bits
   always_comb begin
      w1c_vec   = reg_wr ? (reg_wdata & W1C_MASK) : 32'h0000_0000;
      onak_next = evt.out_nak_applied ? 1'b1 : (lvl.clear_out_nak_ctrl ? 1'b0 : onak_reg);
      inak_next = evt.in_nak_sampled ? 1'b1 : (lvl.clear_in_nak_ctrl ? 1'b0 : inak_reg);
      sts_next  = (sts_reg & ~w1c_vec & W1C_MASK) | (set_vec & W1C_MASK);
      if (!cfg.two_wire_enabled) begin
         sts_next[B_TWI] = 1'b0;
      end
      if (!cfg.carkit_enabled) begin
         sts_next[B_CAR] = 1'b0;
      end
      sts_next[B_PORT] = cfg.host_mode && lvl.port_pending;
      sts_next[B_OEP]  = lvl.oep_pending;
      sts_next[B_IEP]  = lvl.iep_pending;
      sts_next[B_ONAK] = onak_next;
      sts_next[B_INAK] = inak_next;
      sts_next[B_NPTX] = !cfg.dedicated_tx_fifos_option && lvl.np_queue_room
                         && (cfg.nonperiodic_empty_level ? lvl.np_full_empty : lvl.np_half_empty);
      sts_next[B_RXF]  = lvl.rx_packets;
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         sts_reg      <= STATUS_RESET;
         onak_reg     <= 1'b0;
         inak_reg     <= 1'b0;
         idle_cnt_reg <= 17'h0_0000;
         irq_reg      <= 1'b0;
         resume_reg   <= 1'b0;
         nakr_reg     <= 1'b0;
      end else begin
         sts_reg      <= sts_next;
         onak_reg     <= onak_next;
         inak_reg     <= inak_next;
         idle_cnt_reg <= idle_cnt_next;
         irq_reg      <= |(sts_next & irq_mask);
         resume_reg   <= set_vec[B_RSTR];
         nakr_reg     <= inak_next && !lvl.stall_active;
      end
   end

   assign core_interrupt_status = sts_reg;
   assign irq                   = irq_reg;
   assign restore_resume        = resume_reg;
   assign in_nak_reply          = nakr_reg;

   // checks
   property p_irq;
      @(posedge clk) disable iff (!rst_sync_b) |(sts_reg & irq_mask) |-> ##1 irq || $changed(irq_mask) || $changed(sts_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_sticky;
      @(posedge clk) disable iff (!rst_sync_b) sts_reg[B_ENUM] && !(reg_wr && reg_wdata[B_ENUM]) |=> sts_reg[B_ENUM];
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky bit lost");
   property p_clear;
      @(posedge clk) disable iff (!rst_sync_b) reg_wr && reg_wdata[B_BRST] && !evt.bus_reset |=> !sts_reg[B_BRST];
   endproperty
   a_clear: assert property (p_clear) else $error("w1c failed");
   property p_enum;
      @(posedge clk) disable iff (!rst_sync_b) evt.enum_done |=> sts_reg[B_ENUM];
   endproperty
   a_enum: assert property (p_enum) else $error("enum not set");
   property p_twi;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.two_wire_enabled |=> !sts_reg[B_TWI] || $changed(cfg.two_wire_enabled);
   endproperty
   a_twi: assert property (p_twi) else $error("two wire bit not zero");
   property p_fetch;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.dma_mode && !sts_reg[B_FETCH] |=> !sts_reg[B_FETCH];
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch set outside dma");
   property p_rxf;
      @(posedge clk) disable iff (!rst_sync_b) lvl.rx_packets |=> sts_reg[B_RXF];
   endproperty
   a_rxf: assert property (p_rxf) else $error("rx level lost");
   property p_onak;
      @(posedge clk) disable iff (!rst_sync_b) evt.out_nak_applied |=> sts_reg[B_ONAK];
   endproperty
   a_onak: assert property (p_onak) else $error("out nak flag missing");
   property p_early;
      @(posedge clk) disable iff (!rst_sync_b) $rose(sts_reg[B_EARLY]) |-> idle_cnt_reg == 17'(IDLE_CYC);
   endproperty
   a_early: assert property (p_early) else $error("early idle timing");
   property p_stall;
      @(posedge clk) disable iff (!rst_sync_b) lvl.stall_active |=> !in_nak_reply;
   endproperty
   a_stall: assert property (p_stall) else $error("nak over stall");

   property p_rstdet;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.host_mode && evt.reset_in_suspend && cfg.in_l2_suspend && cfg.partial_or_gated && !cfg.hibernating |=> sts_reg[B_RSTDET];
   endproperty
   a_rstdet: assert property (p_rstdet) else $error("suspend reset not set");

   property p_rstdet_hib;
      @(posedge clk) disable iff (!rst_sync_b) cfg.hibernating && !sts_reg[B_RSTDET] |=> !sts_reg[B_RSTDET];
   endproperty
   a_rstdet_hib: assert property (p_rstdet_hib) else $error("suspend reset in hibernation");

   property p_fetch_set;
      @(posedge clk) disable iff (!rst_sync_b) cfg.dma_mode && evt.fetch_stalled |=> sts_reg[B_FETCH];
   endproperty
   a_fetch_set: assert property (p_fetch_set) else $error("fetch stall not set");

   property p_hper;
      @(posedge clk) disable iff (!rst_sync_b) cfg.host_mode && evt.periodic_incomplete |=> sts_reg[B_INCOUT];
   endproperty
   a_hper: assert property (p_hper) else $error("host periodic not set");

   property p_isoout;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.host_mode && evt.iso_out_incomplete && evt.frame_interval |=> sts_reg[B_INCOUT] && sts_reg[B_PERIODIC_FRAME_END_FLAG];
   endproperty
   a_isoout: assert property (p_isoout) else $error("iso out incomplete not set");

   property p_isoin;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.sg_dma_mode && evt.iso_in_incomplete && evt.frame_interval && !cfg.host_mode |=> sts_reg[B_INCIN] && sts_reg[B_PERIODIC_FRAME_END_FLAG];
   endproperty
   a_isoin: assert property (p_isoin) else $error("iso in incomplete not set");

   property p_isoin_sg;
      @(posedge clk) disable iff (!rst_sync_b) cfg.sg_dma_mode && !sts_reg[B_INCIN] |=> !sts_reg[B_INCIN];
   endproperty
   a_isoin_sg: assert property (p_isoin_sg) else $error("iso in set in scatter mode");

   property p_oep;
      @(posedge clk) disable iff (!rst_sync_b) 1'b1 |=> sts_reg[B_OEP] == $past(lvl.oep_pending);
   endproperty
   a_oep: assert property (p_oep) else $error("out endpoint summary wrong");

   property p_iep;
      @(posedge clk) disable iff (!rst_sync_b) 1'b1 |=> sts_reg[B_IEP] == $past(lvl.iep_pending);
   endproperty
   a_iep: assert property (p_iep) else $error("in endpoint summary wrong");

   property p_mis;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.dedicated_tx_fifos_option && evt.mismatch_expired |=> sts_reg[B_MIS];
   endproperty
   a_mis: assert property (p_mis) else $error("mismatch not set");

   property p_mis_ded;
      @(posedge clk) disable iff (!rst_sync_b) cfg.dedicated_tx_fifos_option && !sts_reg[B_MIS] |=> !sts_reg[B_MIS];
   endproperty
   a_mis_ded: assert property (p_mis_ded) else $error("mismatch set with dedicated fifos");

   property p_rstr;
      @(posedge clk) disable iff (!rst_sync_b) cfg.power_saving_option == HIBERNATE_OPT && evt.restore_done |=> sts_reg[B_RSTR] && restore_resume;
   endproperty
   a_rstr: assert property (p_rstr) else $error("restore done not set");

   property p_periodic_frame_end_flag;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.host_mode && evt.frame_interval |=> sts_reg[B_PERIODIC_FRAME_END_FLAG];
   endproperty
   a_periodic_frame_end_flag: assert property (p_periodic_frame_end_flag) else $error("frame end not set");

   property p_drop;
      @(posedge clk) disable iff (!rst_sync_b) evt.iso_out_drop |=> sts_reg[B_DROP];
   endproperty
   a_drop: assert property (p_drop) else $error("iso drop not set");

   property p_brst;
      @(posedge clk) disable iff (!rst_sync_b) evt.bus_reset |=> sts_reg[B_BRST];
   endproperty
   a_brst: assert property (p_brst) else $error("bus reset not set");

   property p_susp;
      @(posedge clk) disable iff (!rst_sync_b) evt.bus_suspend |=> sts_reg[B_SUSP];
   endproperty
   a_susp: assert property (p_susp) else $error("suspend not set");

   property p_car;
      @(posedge clk) disable iff (!rst_sync_b) !cfg.carkit_enabled |=> !sts_reg[B_CAR] || $changed(cfg.carkit_enabled);
   endproperty
   a_car: assert property (p_car) else $error("carkit bit not zero");

   property p_inak;
      @(posedge clk) disable iff (!rst_sync_b) evt.in_nak_sampled |=> sts_reg[B_INAK];
   endproperty
   a_inak: assert property (p_inak) else $error("in nak flag missing");

   property p_onak_clr;
      @(posedge clk) disable iff (!rst_sync_b) lvl.clear_out_nak_ctrl && !evt.out_nak_applied |=> !sts_reg[B_ONAK];
   endproperty
   a_onak_clr: assert property (p_onak_clr) else $error("out nak flag not cleared");

   property p_nptx;
      @(posedge clk) disable iff (!rst_sync_b) 1'b1 |=> sts_reg[B_NPTX] == ($past(lvl.np_queue_room)
         && !$past(cfg.dedicated_tx_fifos_option)
         && ($past(cfg.nonperiodic_empty_level) ? $past(lvl.np_full_empty) : $past(lvl.np_half_empty)));
   endproperty
   a_nptx: assert property (p_nptx) else $error("tx room flag wrong");

   property p_port;
      @(posedge clk) disable iff (!rst_sync_b) 1'b1 |=> sts_reg[B_PORT] == ($past(cfg.host_mode) && $past(lvl.port_pending));
   endproperty
   a_port: assert property (p_port) else $error("port summary wrong");

   property p_rxf_clr;
      @(posedge clk) disable iff (!rst_sync_b) !lvl.rx_packets |=> !sts_reg[B_RXF];
   endproperty
   a_rxf_clr: assert property (p_rxf_clr) else $error("rx level stuck");

   property p_w1c_zero;
      @(posedge clk) disable iff (!rst_sync_b) reg_wr && !reg_wdata[B_DROP] && sts_reg[B_DROP] |=> sts_reg[B_DROP];
   endproperty
   a_w1c_zero: assert property (p_w1c_zero) else $error("zero write cleared bit");

   property p_race;
      @(posedge clk) disable iff (!rst_sync_b) reg_wr && reg_wdata[B_BRST] && evt.bus_reset |=> sts_reg[B_BRST];
   endproperty
   a_race: assert property (p_race) else $error("clear beat set");

   property p_irq_off;
      @(posedge clk) disable iff (!rst_sync_b) ~|(sts_next & irq_mask) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without source");

   c_enum: cover property (@(posedge clk) disable iff (!rst_sync_b) evt.enum_done ##1 irq);
   c_early: cover property (@(posedge clk) disable iff (!rst_sync_b) $rose(sts_reg[B_EARLY]));
   c_race: cover property (@(posedge clk) disable iff (!rst_sync_b) reg_wr && reg_wdata[B_BRST] && evt.bus_reset);
endmodule

// *** tb/uocis_usb_side.sv ***
`timescale 1ns/10ps
module uocis_usb_side
   import uocis_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // bench requests
   input  wire uocis_evt_s req,
   input  wire logic       quiet,
   // toward the core
   output uocis_evt_s      evt
);
   uocis_evt_s last_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         evt      <= '0;
         last_reg <= '0;
      end else begin
         evt          <= uocis_evt_s'(req & ~last_reg);  // one-cycle pulses
         evt.bus_idle <= quiet;                           // idle is a level
         last_reg     <= req;
      end
   end
endmodule

// *** tb/usb_otg_core_interrupt_status_tb.sv ***
`timescale 1ns/10ps
module usb_otg_core_interrupt_status_tb;
   import uocis_pkg::*;
   logic        clk       = 1'b0;
   logic        rst_b     = 1'b0;
   logic        reg_wr    = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] irq_mask  = 32'h01ff_ffd0;
   logic        quiet     = 1'b0;
   logic        chk       = 1'b0;
   logic [31:0] seed      = 32'h0001_392b;
   uocis_evt_s  req       = '0;
   uocis_cfg_s  cfg       = 12'h096;
   uocis_lvl_s  lvl       = 10'h050;
   uocis_evt_s  evt;
   logic [31:0] sts;
   logic        irq;
   logic        nak_rep;
   logic        resume;
   logic        resume_exp = 1'b0;
   logic [34:0] note_q[$];
   int          miscompares = 0;
   int          samples_checked = 0;
   localparam logic [17:0] EV_T [12] = '{18'h00080, 18'h00040, 18'h00020, 18'h00100, 18'h00200, 18'h02200,
                                         18'h01200, 18'h00800, 18'h00400, 18'h00008, 18'h00004, 18'h08000};
   localparam logic [31:0] BIT_T [12] = '{32'h0000_2000, 32'h0000_1000, 32'h0000_0800, 32'h0000_4000,
                                          32'h0000_8000, 32'h0020_8000, 32'h0010_8000, 32'h0002_0000,
                                          32'h0001_0000, 32'h0000_0200, 32'h0000_0100, 32'h0000_0000};

   uocis_usb_side far_end (.clk(clk), .rst_b(rst_b), .req(req), .quiet(quiet), .evt(evt));
   uocis_core dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .irq_mask(irq_mask),
                   .evt(evt), .cfg(cfg), .lvl(lvl), .core_interrupt_status(sts), .restore_resume(resume),
                   .in_nak_reply(nak_rep), .irq(irq));

   initial begin
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic compare_res(input logic [34:0] exp);
      samples_checked++;
      if ({resume, nak_rep, irq, sts} !== exp) begin
         miscompares++;
         $display("wrong value resume_reply_irq_status expected %h seen %h", exp, {resume, nak_rep, irq, sts});
      end
   endtask

   task automatic expect_sts(input logic [31:0] s);
      note_q.push_back({resume_exp, s[6] & ~lvl.stall_active, |(s & irq_mask), s});
      resume_exp = 1'b0;
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
   endtask

   task automatic fire(input logic [17:0] e);
      @(posedge clk);
      req <= e;
      resume_exp = e[10] && (cfg.power_saving_option == HIBERNATE_OPT);
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] w);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_wdata <= w;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic set_lvl(input logic [9:0] v);
      @(posedge clk);
      lvl <= v;
      @(posedge clk);
   endtask

   always @(negedge clk) begin
      if (chk) begin
         compare_res(note_q.pop_front());
      end
   end

   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      expect_sts(STATUS_RESET);
      for (int i = 0; i < 12; i++) begin
         fire(EV_T[i]);
         expect_sts(STATUS_RESET | BIT_T[i]);
         wr(32'h0);
         expect_sts(STATUS_RESET | BIT_T[i]);
         wr(BIT_T[i]);
         expect_sts(STATUS_RESET);
      end
      cfg.two_wire_enabled <= 1'b0;
      cfg.carkit_enabled   <= 1'b0;
      fire(18'h0000c);
      expect_sts(STATUS_RESET);
      cfg.dma_mode      <= 1'b1;
      cfg.in_l2_suspend <= 1'b1;
      fire(18'h18000);
      expect_sts(32'h00c0_0020);
      wr(32'h00c0_0000);
      expect_sts(STATUS_RESET);
      cfg.hibernating <= 1'b1;
      fire(18'h10000);
      expect_sts(STATUS_RESET);
      for (int k = 0; k < 4; k++) begin
         fire(18'h03fe0);
         expect_sts(32'h0033_f820);
         seed = lfsr(seed);
         wr(seed);
         expect_sts(32'h0033_f820 & ~(seed & W1C_MASK));
         wr(32'hffff_ffff);
         expect_sts(STATUS_RESET);
      end
      set_lvl(10'h054);
      fire(18'h00003);
      expect_sts(32'h0000_00e0);
      wr(32'h0000_00c0);
      expect_sts(32'h0000_00e0);
      set_lvl(10'h052);
      expect_sts(32'h0000_0060);
      set_lvl(10'h051);
      expect_sts(STATUS_RESET);
      set_lvl(10'h3d8);
      expect_sts(32'h000c_0030);
      cfg.host_mode <= 1'b1;
      set_lvl(10'h0d0);
      expect_sts(32'h0100_0020);
      cfg.host_mode <= 1'b0;
      cfg.nonperiodic_empty_level <= 1'b1;
      set_lvl(10'h050);
      expect_sts(32'h0);
      cfg.nonperiodic_empty_level <= 1'b0;
      quiet <= 1'b1;
      repeat (74990) @(posedge clk);
      expect_sts(STATUS_RESET);
      repeat (20) @(posedge clk);
      expect_sts(32'h0000_0420);
      wr(32'h0000_0400);
      repeat (50) @(posedge clk);
      expect_sts(STATUS_RESET);
      repeat (2) @(posedge clk);
      summarize();
   end
endmodule
